// [src/swl_top.sv]
// serial word loader with register bank and two gain holding buffers
// assumes serial clock is far slower than ref_clk (80 ns vs 10 ns)
`timescale 1ns/100ps
// Behaviour
// - while the load strobe is low each serial clock rise shifts one data bit in.
// - only the most recent 32 shifted bits are kept.
// - a rising load strobe copies the word into the register chosen by its low four bits.
// - a serial output shifts the most recently loaded word back to the host while the next word is shifted in.
// - each channel latch pin gates a holding buffer between its selected gain source (pins or serial register) and its gain stage.
// - a select bit picks serial register gain at 0 or parallel pin gain at 1.
module swl_top (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              serial_clk,
  input  wire logic              serial_data_in,
  input  wire logic              word_load_strobe,
  input  wire logic [5:0]        chan_a_gain_code_pins,
  input  wire logic [5:0]        chan_b_gain_code_pins,
  input  wire logic              chan_a_latch,
  input  wire logic              chan_b_latch,
  output logic                   serial_readback_out,
  output logic [5:0]             chan_a_gain,
  output logic [5:0]             chan_b_gain
);
  localparam int W  = swl_pkg::WORD_W;
  localparam int GW = swl_pkg::GAIN_W;

  // synchronised link pins
  logic sclk_s;
  logic sdat_s;
  logic le_s;
  logic lat_a_s;
  logic lat_b_s;
  logic [GW-1:0] pa_s;
  logic [GW-1:0] pb_s;

  swl_sync u_sclk (.clk(ref_clk), .nrst(nrst), .d(serial_clk),       .q(sclk_s));
  swl_sync u_sdat (.clk(ref_clk), .nrst(nrst), .d(serial_data_in),   .q(sdat_s));
  swl_sync #(.RST_VAL(1'b1)) u_le (
    .clk(ref_clk), .nrst(nrst), .d(word_load_strobe), .q(le_s));
  swl_sync u_lta  (.clk(ref_clk), .nrst(nrst), .d(chan_a_latch),     .q(lat_a_s));
  swl_sync u_ltb  (.clk(ref_clk), .nrst(nrst), .d(chan_b_latch),     .q(lat_b_s));

  genvar gi;
  generate
    for (gi = 0; gi < GW; gi++) begin : g_pins
      swl_sync u_pa (.clk(ref_clk), .nrst(nrst), .d(chan_a_gain_code_pins[gi]), .q(pa_s[gi]));
      swl_sync u_pb (.clk(ref_clk), .nrst(nrst), .d(chan_b_gain_code_pins[gi]), .q(pb_s[gi]));
    end
  endgenerate

  // edge history, read only after the synchronisers
  logic sclk_d_r;
  logic le_d_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d_r <= 1'b0;
      le_d_r   <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      le_d_r   <= le_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire le_rise   = le_s & ~le_d_r;

  wire do_shift  = sclk_rise & ~le_s;

  logic [W-1:0] shift_r;
  logic [W-1:0] shift_nxt;
  assign shift_nxt = do_shift ? {shift_r[W-2:0], sdat_s} : shift_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      shift_r <= swl_pkg::REG_RST_VAL;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // register bank
  logic [W-1:0] regs_r [swl_pkg::NUM_REGS];
  wire  [swl_pkg::ADDR_W-1:0] sel_idx = shift_r[swl_pkg::ADDR_W-1:0];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < swl_pkg::NUM_REGS; i++) begin
        regs_r[i] <= swl_pkg::REG_RST_VAL;
      end
    end else if (le_rise) begin
      regs_r[sel_idx] <= shift_r;
    end
  end

  // readback: strobe rise arms the addressed word, each falling clock while the strobe is low sends a bit msb first.
  // falling edge timing lets the host sample on the following rise.
  logic [W-1:0] rb_r;
  logic [W-1:0] rb_nxt;
  logic         sdo_r;
  logic         sdo_nxt;
  assign rb_nxt  = le_rise ? shift_r :
                   (sclk_fall & ~le_s) ? {rb_r[W-2:0], 1'b0} : rb_r;
  assign sdo_nxt = rb_nxt[W-1];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rb_r  <= swl_pkg::REG_RST_VAL;
      sdo_r <= 1'b0;
    end else begin
      rb_r  <= rb_nxt;
      sdo_r <= sdo_nxt;
    end
  end
  assign serial_readback_out = sdo_r;

  // gain source selection
  wire [W-1:0] ctrl_w   = regs_r[swl_pkg::CTRL_REG_IDX];
  wire [W-1:0] gainr_w  = regs_r[swl_pkg::GAIN_REG_IDX];
  wire         use_pins = ctrl_w[swl_pkg::GAIN_SEL_BIT];
  // code and latch of one channel travel together
  swl_pkg::swl_gain_in_t pin_a;
  swl_pkg::swl_gain_in_t pin_b;
  assign pin_a = {pa_s, lat_a_s};
  assign pin_b = {pb_s, lat_b_s};
  wire [GW-1:0] src_a   = use_pins ? pin_a.code : gainr_w[swl_pkg::GAIN_A_LSB +: GW];
  wire [GW-1:0] src_b   = use_pins ? pin_b.code : gainr_w[swl_pkg::GAIN_B_LSB +: GW];

  // holds old gain while latch low
  logic [GW-1:0] gain_a_r;
  logic [GW-1:0] gain_b_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gain_a_r <= swl_pkg::GAIN_RST_VAL;
      gain_b_r <= swl_pkg::GAIN_RST_VAL;
    end else begin
      if (pin_a.latch) gain_a_r <= src_a;
      if (pin_b.latch) gain_b_r <= src_b;
    end
  end
  assign chan_a_gain = gain_a_r;
  assign chan_b_gain = gain_b_r;

  property p_shift;
    @(posedge ref_clk) disable iff (!nrst)
      do_shift |=> shift_r == {$past(shift_r[W-2:0]), $past(sdat_s)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");

  property p_keep;
    @(posedge ref_clk) disable iff (!nrst)
      do_shift |=> shift_r[W-1:1] == $past(shift_r[W-2:0]);
  endproperty
  a_keep: assert property (p_keep) else $error("history lost");

  property p_hold;
    @(posedge ref_clk) disable iff (!nrst)
      (le_s && !le_rise) [*2] |-> $stable(shift_r);
  endproperty
  a_hold: assert property (p_hold) else $error("shift moved under strobe");

  property p_load;
    @(posedge ref_clk) disable iff (!nrst)
      le_rise |=> regs_r[$past(sel_idx)] == $past(shift_r);
  endproperty
  a_load: assert property (p_load) else $error("register not loaded");

  property p_rb;
    @(posedge ref_clk) disable iff (!nrst)
      le_rise |=> ##1 serial_readback_out == $past(shift_r[W-1], 2);
  endproperty
  a_rb: assert property (p_rb) else $error("readback msb wrong");

  property p_lat;
    @(posedge ref_clk) disable iff (!nrst)
      !lat_a_s |=> $stable(chan_a_gain);
  endproperty
  a_lat: assert property (p_lat) else $error("gain a moved while held");

  property p_sel;
    @(posedge ref_clk) disable iff (!nrst)
      (lat_b_s && use_pins) |=> chan_b_gain == $past(pb_s);
  endproperty
  a_sel: assert property (p_sel) else $error("gain b source wrong");

  property p_ser;
    @(posedge ref_clk) disable iff (!nrst)
      (lat_a_s && !use_pins) |=> chan_a_gain == $past(gainr_w[swl_pkg::GAIN_A_LSB +: GW]);
  endproperty
  a_ser: assert property (p_ser) else $error("gain a serial source wrong");

  property p_lat_b;
    @(posedge ref_clk) disable iff (!nrst)
      !lat_b_s |=> $stable(chan_b_gain);
  endproperty
  a_lat_b: assert property (p_lat_b) else $error("gain b moved while held");

  property p_par_a;
    @(posedge ref_clk) disable iff (!nrst)
      (lat_a_s && use_pins) |=> chan_a_gain == $past(pa_s);
  endproperty
  a_par_a: assert property (p_par_a) else $error("gain a parallel source wrong");

  property p_ser_b;
    @(posedge ref_clk) disable iff (!nrst)
      (lat_b_s && !use_pins) |=> chan_b_gain == $past(gainr_w[swl_pkg::GAIN_B_LSB +: GW]);
  endproperty
  a_ser_b: assert property (p_ser_b) else $error("gain b serial source wrong");
endmodule // swl_top

// [src/swl_pkg.sv]
// package for the serial word loader and gain port
// assumes a single 100 MHz core clock; link pins are asynchronous
package swl_pkg;
  localparam int WORD_W        = 32;
  localparam int ADDR_W        = 4;
  localparam int NUM_REGS      = 16;
  localparam int GAIN_W        = 6;
  // register holding the gain source select bit
  localparam logic [3:0] CTRL_REG_IDX   = 4'h7;
  localparam int         GAIN_SEL_BIT   = 22;
  // register holding serial gain codes
  localparam logic [3:0] GAIN_REG_IDX   = 4'he;
  localparam int         GAIN_A_LSB     = 12;
  localparam int         GAIN_B_LSB     = 6;
  localparam logic [31:0] REG_RST_VAL   = 32'h0000_0000;
  localparam logic [5:0]  GAIN_RST_VAL  = 6'h00;

  typedef struct packed {
    logic [5:0] code;
    logic       latch;
  } swl_gain_in_t;
endpackage : swl_pkg

// [src/swl_sync.sv]
// two flop synchroniser for one asynchronous level
// assumes the destination clock is the core clock
`timescale 1ns/100ps
module swl_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // swl_sync

// [bench/swl_host.sv]
// host model: serial clock, data and load strobe
// assumes 80 ns link clock, idle low, strobe idle high
`timescale 1ns/100ps
module swl_host (
  output logic      serial_clk,
  output logic      serial_data_in,
  output logic      word_load_strobe,
  input  wire logic serial_readback_out
);
  logic [31:0] rb;
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    word_load_strobe = 1'b1;
    rb = 32'h0;
  end
  // readback sampled just before each fall
  task automatic bit_out(input logic b);
    serial_data_in = b;
    #40 serial_clk = 1'b1;
    #40 rb = {rb[30:0], serial_readback_out};
    serial_clk = 1'b0;
  endtask
  task automatic send(input logic [3:0] pre, input bit use_pre, input logic [31:0] w);
    word_load_strobe = 1'b0;
    if (use_pre) for (int i = 3; i >= 0; i--) bit_out(pre[i]);
    for (int i = 31; i >= 0; i--) bit_out(w[i]);
    // released data line must not keep its last value
    #40 serial_data_in = ~w[0];
    word_load_strobe = 1'b1;
    #100;
  endtask
  task automatic idle_clk(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
  endtask
endmodule // swl_host

// [bench/serial_word_loader_gain_port_tb.sv]
// bench: register and latch model compared with swl_top
// assumes swl_host drives the serial pins
`timescale 1ns/100ps
module serial_word_loader_gain_port_tb;
  logic        ref_clk, nrst, s_clk, s_din, s_le, s_out, la, lb, oa, ob;
  logic [5:0]  pa, pb, ga, gb, ea, eb;
  logic [31:0] m [16];
  logic [31:0] last, w;
  int          failures, compares, cyc;
  swl_top i_dut (.ref_clk(ref_clk), .nrst(nrst), .serial_clk(s_clk), .serial_data_in(s_din),
    .word_load_strobe(s_le), .chan_a_gain_code_pins(pa), .chan_b_gain_code_pins(pb),
    .chan_a_latch(la), .chan_b_latch(lb), .serial_readback_out(s_out),
    .chan_a_gain(ga), .chan_b_gain(gb));
  swl_host i_host (.serial_clk(s_clk), .serial_data_in(s_din), .word_load_strobe(s_le),
    .serial_readback_out(s_out));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_gain(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch gain at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rb(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch readback at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic [3:0] pre, input bit use_pre, input logic [31:0] wd);
    @(posedge ref_clk) #1;
    i_host.send(pre, use_pre, wd);
    if (!use_pre) cmp_rb(i_host.rb, last);
    m[wd[3:0]] = wd;
    last = wd;
  endtask
  task automatic step();
    logic [5:0] sa, sb;
    @(posedge ref_clk) #1;
    pa = 6'($urandom);
    pb = 6'($urandom);
    repeat (10) @(posedge ref_clk);
    #1 oa = la;
    ob = lb;
    la = 1'($urandom);
    lb = 1'($urandom);
    repeat (10) @(posedge ref_clk);
    #1 sa = m[swl_pkg::CTRL_REG_IDX][swl_pkg::GAIN_SEL_BIT] ? pa
           : m[swl_pkg::GAIN_REG_IDX][swl_pkg::GAIN_A_LSB +: 6];
    sb = m[swl_pkg::CTRL_REG_IDX][swl_pkg::GAIN_SEL_BIT] ? pb
           : m[swl_pkg::GAIN_REG_IDX][swl_pkg::GAIN_B_LSB +: 6];
    // source stable across the latch drop, so either level passes it
    if (la | oa) ea = sa;
    if (lb | ob) eb = sb;
    cmp_gain({ga, gb}, {ea, eb});
  endtask
  initial begin
    nrst = 1'b0;
    pa = 6'h00;
    pb = 6'h00;
    la = 1'b0;
    lb = 1'b0;
    ea = 6'h00;
    eb = 6'h00;
    last = 32'h0;
    for (int i = 0; i < 16; i++) m[i] = 32'h0;
    void'($urandom(49131));
    repeat (4) @(posedge ref_clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 cmp_gain({ga, gb}, 12'h000);
    for (int i = 0; i < 24; i++) begin
      w = $urandom;
      w[3:0] = (i > 15) ? (i[0] ? 4'h7 : 4'he) : i[3:0];
      // both gain sources used, serial one left in force at the end
      if (i == 17) w[swl_pkg::GAIN_SEL_BIT] = 1'b1;
      if (i == 23) w[swl_pkg::GAIN_SEL_BIT] = 1'b0;
      load(4'h0, 1'b0, w);
      step();
    end
    // four extra leading bits must fall away
    w = $urandom;
    w[3:0] = 4'he;
    load(4'($urandom), 1'b1, w);
    step();
    i_host.idle_clk(8'($urandom));
    step();
    load(4'h0, 1'b0, 32'h0000_0005);
    stop_test();
  end
endmodule // serial_word_loader_gain_port_tb
